// File: rtl/bosm_regs.svh
`ifndef BOSM_REGS_SVH
`define BOSM_REGS_SVH

// ==========================================================
// Register map (index addresses on the 8-bit register port)
`define BOSM_MEM_CFG_ONE_ADDR 8'h66
`define BOSM_FUNC_SEL_ADDR 8'h71

// ==========================================================
// Memory configuration one fields
`define BOSM_MCFG_BUS_LO 5
`define BOSM_MCFG_BUS_HI 6
`define BOSM_MCFG_SW_MASK 8'h9f
`define BOSM_MCFG_RST 8'h00

// ==========================================================
// Function select fields
`define BOSM_FSEL_SRAM 0
`define BOSM_FSEL_PAR_BIDIR 1
`define BOSM_FSEL_OSC_BAUD 2
`define BOSM_FSEL_CLK14 3
`define BOSM_FSEL_MASK 8'h0f
`define BOSM_FSEL_RST 8'h00

// ==========================================================
// Strap encodings {high, low}
`define BOSM_STRAP_LOCAL 2'h2
`define BOSM_STRAP_MAX_ISA 2'h3
`define BOSM_STRAP_RST 2'h2

// ==========================================================
// Shared pin indices
`define BOSM_NPINS 23
`define BOSM_PIN_A12 0
`define BOSM_PIN_A13 1
`define BOSM_PIN_A14 2
`define BOSM_PIN_A15 3
`define BOSM_PIN_A16 4
`define BOSM_PIN_A17 5
`define BOSM_PIN_A23 11
`define BOSM_PIN_CPU_RDY 12
`define BOSM_PIN_DC 13
`define BOSM_PIN_MIO 14
`define BOSM_PIN_LOCAL_READY_IN 15
`define BOSM_PIN_WR 16
`define BOSM_PIN_TIE_LOW 17
`define BOSM_PIN_PU164 18
`define BOSM_PIN_BHE 19
`define BOSM_PIN_PU179 20
`define BOSM_PIN_BLE 21
`define BOSM_PIN_ADS 22
`define BOSM_OE_LOCAL 23'h697fff
`define BOSM_OE_MAX_ISA 23'h001fff

`endif

// File: rtl/bosm_pkg.sv
package bosm_pkg;

    typedef enum logic {
        BOSM_LOCAL_BUS,
        BOSM_MAX_ISA
    } bosm_mode_t;

    typedef enum logic {
        BOSM_SAMPLING,
        BOSM_LOCKED
    } bosm_cfg_state_t;

endpackage

// File: rtl/bosm_pin_mux.sv
`timescale 1ns/1ns
`include "bosm_regs.svh"
// Operation
// - Power-up: straps captured at both resets' release
// - Later I/O reset alone keeps configuration
// - Each main reset resamples both straps
// - Straps 1,0 local; 1,1 maximum ISA
// - Selection readable in bits 6:5 at 66h
// - Out of reset, straps drive modem outputs
// - Software bits select four other functions
// - ISA address latch enable on A12 pin
// - DMA requests 0,3,6,7 on status pins
// - DMA acknowledges 0,3,6,7 on A16,A15,A13,A14
// - IRQ5,7,9,10,11 on pull and byte-enable pins
// - Upper ISA address on A23-A17 pins
// - Below-1M memory decode on CPU ready pin
module bosm_pin_mux (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic main_reset_in_n_i,
    input wire logic io_side_reset_n_i,
    input wire logic bus_strap_high_i,
    output logic bus_strap_high_o,
    output logic bus_strap_high_oe_o,
    input wire logic bus_strap_low_i,
    output logic bus_strap_low_o,
    output logic bus_strap_low_oe_o,
    input wire logic modem_dtr_i,
    input wire logic modem_rts_i,
    input wire logic [`BOSM_NPINS-1:0] shared_pin_i,
    output logic [`BOSM_NPINS-1:0] shared_pin_o,
    output logic [`BOSM_NPINS-1:0] shared_pin_oe_o,
    input wire logic [11:0] core_addr_i,
    input wire logic core_cpu_ready_out_i,
    input wire logic core_dc_i,
    input wire logic core_mio_i,
    input wire logic core_wr_i,
    input wire logic core_byte_high_enable_i,
    input wire logic core_byte_low_enable_i,
    input wire logic core_address_strobe_i,
    output logic local_ready_in_o,
    input wire logic isa_ale_i,
    input wire logic [3:0] isa_dack_i,
    input wire logic [6:0] isa_la_i,
    input wire logic isa_mem_below_1m_i,
    output logic [3:0] isa_drq_o,
    output logic [4:0] isa_irq_o,
    output logic isa_zero_wait_o,
    output logic bus_max_isa_o,
    output logic mem_sram_sel_o,
    output logic par_bidir_o,
    output logic osc_baud_sel_o,
    output logic clk14_en_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);

    function automatic bosm_pkg::bosm_mode_t bosm_decode(input logic [1:0] straps);
        if (straps == `BOSM_STRAP_MAX_ISA) begin
            return bosm_pkg::BOSM_MAX_ISA;
        end
        return bosm_pkg::BOSM_LOCAL_BUS;
    endfunction

    function automatic logic [`BOSM_NPINS-1:0] bosm_oe_mask(input bosm_pkg::bosm_mode_t m);
        if (m == bosm_pkg::BOSM_MAX_ISA) begin
            return `BOSM_OE_MAX_ISA;
        end
        return `BOSM_OE_LOCAL;
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic main_s1, main_s2, io_s1, io_s2;
    logic [1:0] strap_s1, strap_s2;
    logic [`BOSM_NPINS-1:0] pin_s1, pin_s2;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_s1 <= 1'b0;
            main_s2 <= 1'b0;
            io_s1 <= 1'b0;
            io_s2 <= 1'b0;
            strap_s1 <= `BOSM_STRAP_RST;
            strap_s2 <= `BOSM_STRAP_RST;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            main_s1 <= main_reset_in_n_i;
            main_s2 <= main_s1;
            io_s1 <= io_side_reset_n_i;
            io_s2 <= io_s1;
            strap_s1 <= {bus_strap_high_i, bus_strap_low_i};
            strap_s2 <= strap_s1;
            pin_s1 <= shared_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    logic both_released;
    assign both_released = main_s2 && io_s2;

    // ==========================================================
    // Strap capture
    bosm_pkg::bosm_cfg_state_t cfg_state;
    logic [1:0] strap_hold;
    logic [1:0] strap_cfg;
    bosm_pkg::bosm_mode_t mode;

    // Hold tracks the pins only while a reset is asserted, so the value
    // latched at release predates our own modem drive on those pins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_hold <= `BOSM_STRAP_RST;
        end else if (cfg_state == bosm_pkg::BOSM_SAMPLING && !both_released) begin
            strap_hold <= strap_s2;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_state <= bosm_pkg::BOSM_SAMPLING;
        end else begin
            unique case (cfg_state)
                bosm_pkg::BOSM_SAMPLING: begin
                    if (both_released) begin
                        cfg_state <= bosm_pkg::BOSM_LOCKED;
                    end
                end
                bosm_pkg::BOSM_LOCKED: begin
                    // I/O reset alone is ignored here
                    if (!main_s2) begin
                        cfg_state <= bosm_pkg::BOSM_SAMPLING;
                    end
                end
            endcase
        end
    end

    // Only updated on the sampling-to-locked step
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_cfg <= `BOSM_STRAP_RST;
            mode <= bosm_pkg::BOSM_LOCAL_BUS;
        end else if (cfg_state == bosm_pkg::BOSM_SAMPLING && both_released) begin
            strap_cfg <= strap_hold;
            mode <= bosm_decode(strap_hold);
        end
    end

    logic locked;
    logic is_isa;
    assign locked = (cfg_state == bosm_pkg::BOSM_LOCKED);
    assign is_isa = (mode == bosm_pkg::BOSM_MAX_ISA);
    assign bus_max_isa_o = is_isa;

    // ==========================================================
    // Strap pins as modem outputs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_strap_high_o <= 1'b0;
            bus_strap_low_o <= 1'b0;
            bus_strap_high_oe_o <= 1'b0;
            bus_strap_low_oe_o <= 1'b0;
        end else begin
            bus_strap_high_o <= modem_dtr_i;
            bus_strap_low_o <= modem_rts_i;
            bus_strap_high_oe_o <= locked && both_released;
            bus_strap_low_oe_o <= locked && both_released;
        end
    end

    // ==========================================================
    // Shared pin outputs
    logic [`BOSM_NPINS-1:0] next_pin_out;

    always_comb begin
        next_pin_out = '0;
        if (is_isa) begin
            next_pin_out[`BOSM_PIN_A12] = isa_ale_i;
            next_pin_out[`BOSM_PIN_A16] = isa_dack_i[0];
            next_pin_out[`BOSM_PIN_A15] = isa_dack_i[1];
            next_pin_out[`BOSM_PIN_A13] = isa_dack_i[2];
            next_pin_out[`BOSM_PIN_A14] = isa_dack_i[3];
            next_pin_out[`BOSM_PIN_A23:`BOSM_PIN_A17] = isa_la_i;
            next_pin_out[`BOSM_PIN_CPU_RDY] = isa_mem_below_1m_i;
        end else begin
            next_pin_out[`BOSM_PIN_A23:`BOSM_PIN_A12] = core_addr_i;
            next_pin_out[`BOSM_PIN_CPU_RDY] = core_cpu_ready_out_i;
            next_pin_out[`BOSM_PIN_DC] = core_dc_i;
            next_pin_out[`BOSM_PIN_MIO] = core_mio_i;
            next_pin_out[`BOSM_PIN_WR] = core_wr_i;
            next_pin_out[`BOSM_PIN_BHE] = core_byte_high_enable_i;
            next_pin_out[`BOSM_PIN_BLE] = core_byte_low_enable_i;
            next_pin_out[`BOSM_PIN_ADS] = core_address_strobe_i;
        end
    end

    // Pins float until a configuration is locked so that nothing fights
    // an external driver while the bus choice is still open
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shared_pin_o <= '0;
            shared_pin_oe_o <= '0;
        end else begin
            shared_pin_o <= next_pin_out;
            shared_pin_oe_o <= locked ? bosm_oe_mask(mode) : '0;
        end
    end

    // ==========================================================
    // Shared pin inputs towards the core
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            local_ready_in_o <= 1'b0;
            isa_drq_o <= '0;
            isa_irq_o <= '0;
            isa_zero_wait_o <= 1'b0;
        end else begin
            local_ready_in_o <= !is_isa && pin_s2[`BOSM_PIN_LOCAL_READY_IN];
            isa_drq_o <= is_isa ? {pin_s2[`BOSM_PIN_WR], pin_s2[`BOSM_PIN_LOCAL_READY_IN],
                pin_s2[`BOSM_PIN_MIO], pin_s2[`BOSM_PIN_DC]} : 4'h0;
            isa_irq_o <= is_isa ? {pin_s2[`BOSM_PIN_BLE], pin_s2[`BOSM_PIN_PU179],
                pin_s2[`BOSM_PIN_BHE], pin_s2[`BOSM_PIN_PU164],
                pin_s2[`BOSM_PIN_TIE_LOW]} : 5'h00;
            isa_zero_wait_o <= is_isa && pin_s2[`BOSM_PIN_ADS];
        end
    end

    // ==========================================================
    // Register port
    logic [7:0] mcfg_sw;
    logic [7:0] fsel;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mcfg_sw <= `BOSM_MCFG_RST;
            fsel <= `BOSM_FSEL_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `BOSM_MEM_CFG_ONE_ADDR) begin
                mcfg_sw <= reg_wdata_i & `BOSM_MCFG_SW_MASK;
            end
            if (reg_addr_i == `BOSM_FUNC_SEL_ADDR) begin
                fsel <= reg_wdata_i & `BOSM_FSEL_MASK;
            end
        end
    end

    assign mem_sram_sel_o = fsel[`BOSM_FSEL_SRAM];
    assign par_bidir_o = fsel[`BOSM_FSEL_PAR_BIDIR];
    assign osc_baud_sel_o = fsel[`BOSM_FSEL_OSC_BAUD];
    assign clk14_en_o = fsel[`BOSM_FSEL_CLK14];

    logic [7:0] mcfg_read;
    always_comb begin
        mcfg_read = mcfg_sw;
        mcfg_read[`BOSM_MCFG_BUS_HI:`BOSM_MCFG_BUS_LO] = strap_cfg;
    end

    // Unmapped indexes read as zero; data stands only in the cycle after
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i && reg_addr_i == `BOSM_MEM_CFG_ONE_ADDR) begin
            reg_rdata_o <= mcfg_read;
        end else if (reg_rd_i && reg_addr_i == `BOSM_FUNC_SEL_ADDR) begin
            reg_rdata_o <= fsel;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // Checks
    default clocking bosm_cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_capture_at_release: assert property (
        !locked && both_released |=> locked && strap_cfg == $past(strap_hold))
        else $error("straps not captured at reset release");

    a_io_reset_ignored: assert property (
        locked && main_s2 && !io_s2 |=> locked && $stable(strap_cfg))
        else $error("io reset changed bus configuration");

    a_main_reset_resample: assert property (
        locked && !main_s2 |=> !locked)
        else $error("main reset did not reopen sampling");

    a_strap_decode: assert property (
        locked |-> (is_isa == (strap_cfg == `BOSM_STRAP_MAX_ISA)))
        else $error("bus mode disagrees with straps");

    a_cfg_readback: assert property (
        reg_rd_i && reg_addr_i == `BOSM_MEM_CFG_ONE_ADDR
        |=> reg_rdata_o[`BOSM_MCFG_BUS_HI:`BOSM_MCFG_BUS_LO] == $past(strap_cfg))
        else $error("bus selection not reported");

    a_strap_modem_drive: assert property (
        locked && both_released |=> bus_strap_high_oe_o && bus_strap_low_oe_o
        && bus_strap_high_o == $past(modem_dtr_i) && bus_strap_low_o == $past(modem_rts_i))
        else $error("strap pin not driving modem output");

    a_strap_release: assert property (
        !locked |=> !bus_strap_high_oe_o && !bus_strap_low_oe_o)
        else $error("strap pin driven during sampling");

    a_func_select: assert property (
        reg_wr_i && reg_addr_i == `BOSM_FUNC_SEL_ADDR
        |=> clk14_en_o == $past(reg_wdata_i[`BOSM_FSEL_CLK14])
        && mem_sram_sel_o == $past(reg_wdata_i[`BOSM_FSEL_SRAM]))
        else $error("function select not applied");

    a_ale_route: assert property (
        is_isa && locked |=> shared_pin_o[`BOSM_PIN_A12] == $past(isa_ale_i))
        else $error("address latch enable misrouted");

    a_drq_route: assert property (
        is_isa && $past(is_isa, 3) |-> isa_drq_o[2] == $past(shared_pin_i[`BOSM_PIN_LOCAL_READY_IN], 3))
        else $error("dma request misrouted");

    a_dack_route: assert property (
        is_isa |=> shared_pin_o[`BOSM_PIN_A16] == $past(isa_dack_i[0])
        && shared_pin_o[`BOSM_PIN_A14] == $past(isa_dack_i[3]))
        else $error("dma acknowledge misrouted");

    a_irq_route: assert property (
        is_isa && $past(is_isa, 3) |-> isa_irq_o[2] == $past(shared_pin_i[`BOSM_PIN_BHE], 3))
        else $error("interrupt request misrouted");

    a_upper_addr: assert property (
        is_isa |=> shared_pin_o[`BOSM_PIN_A23:`BOSM_PIN_A17] == $past(isa_la_i))
        else $error("upper address misrouted");

    a_mem_decode: assert property (
        is_isa |=> shared_pin_o[`BOSM_PIN_CPU_RDY] == $past(isa_mem_below_1m_i))
        else $error("memory decode misrouted");

    a_zero_wait: assert property (
        is_isa && $past(is_isa, 3) |-> isa_zero_wait_o == $past(shared_pin_i[`BOSM_PIN_ADS], 3))
        else $error("zero wait misrouted");

    a_mode_stable: assert property (
        locked && $past(locked) |-> $stable(mode) && $stable(strap_cfg))
        else $error("mode moved while locked");

    c_isa_lock: cover property (!locked ##1 locked && is_isa);
    c_local_lock: cover property (!locked ##1 locked && !is_isa);
    c_io_reset_pulse: cover property (locked && !io_s2 ##1 locked && io_s2);
    c_relock: cover property (locked ##1 !locked ##[1:20] locked);

endmodule

// File: tb/bosm_far_side.sv
`timescale 1ns/1ns
// ==========================================================
// Far side: strap resistors and the bus peripherals on the shared pads
module bosm_far_side (
    input wire logic [1:0] strap_code_i,
    input wire logic high_drv_i,
    input wire logic high_oe_i,
    input wire logic low_drv_i,
    input wire logic low_oe_i,
    input wire logic [22:0] pad_drv_i,
    input wire logic [22:0] pad_oe_i,
    input wire logic [22:0] periph_i,
    output logic strap_high_o,
    output logic strap_low_o,
    output logic [22:0] pad_o
);
    // Undriven strap pins settle to the board resistor level
    assign strap_high_o = high_oe_i ? high_drv_i : strap_code_i[1];
    assign strap_low_o = low_oe_i ? low_drv_i : strap_code_i[0];
    // Peripherals drive a pad only where the device has let go of it
    assign pad_o = (pad_oe_i & pad_drv_i) | (~pad_oe_i & periph_i);
endmodule

// File: tb/bosm_pin_mux_tb.sv
`timescale 1ns/1ns
`include "bosm_regs.svh"
module bosm_pin_mux_tb;
    logic clock_i, rst_n_i, main_rst_n, io_rst_n, strap_hi, strap_lo, dtr, rts;
    logic strap_hi_o, strap_hi_oe, strap_lo_o, strap_lo_oe, local_rdy;
    logic cpu_rdy, dc, mio, wr, byte_hi_en, byte_lo_en, addr_strobe;
    logic ale, below_1m, zws, max_isa, sram, bidir, baud, clk14, rwr, rrd;
    logic [1:0] strap_code;
    logic [3:0] dack, drq;
    logic [4:0] irq;
    logic [6:0] la;
    logic [7:0] raddr, wdata, rdata, sw66;
    logic [11:0] core_addr;
    logic [22:0] pad_i, pad_o, pad_oe, periph;
    int n_mismatch, tests_run;

    bosm_far_side i_bosm_far_side (.strap_code_i(strap_code), .high_drv_i(strap_hi_o),
        .high_oe_i(strap_hi_oe), .low_drv_i(strap_lo_o), .low_oe_i(strap_lo_oe),
        .pad_drv_i(pad_o), .pad_oe_i(pad_oe), .periph_i(periph), .strap_high_o(strap_hi),
        .strap_low_o(strap_lo), .pad_o(pad_i));

    bosm_pin_mux i_bosm_pin_mux (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .main_reset_in_n_i(main_rst_n), .io_side_reset_n_i(io_rst_n),
        .bus_strap_high_i(strap_hi), .bus_strap_high_o(strap_hi_o),
        .bus_strap_high_oe_o(strap_hi_oe), .bus_strap_low_i(strap_lo),
        .bus_strap_low_o(strap_lo_o), .bus_strap_low_oe_o(strap_lo_oe),
        .modem_dtr_i(dtr), .modem_rts_i(rts), .shared_pin_i(pad_i), .shared_pin_o(pad_o),
        .shared_pin_oe_o(pad_oe), .core_addr_i(core_addr), .core_cpu_ready_out_i(cpu_rdy),
        .core_dc_i(dc), .core_mio_i(mio), .core_wr_i(wr),
        .core_byte_high_enable_i(byte_hi_en), .core_byte_low_enable_i(byte_lo_en),
        .core_address_strobe_i(addr_strobe), .local_ready_in_o(local_rdy),
        .isa_ale_i(ale), .isa_dack_i(dack), .isa_la_i(la), .isa_mem_below_1m_i(below_1m),
        .isa_drq_o(drq), .isa_irq_o(irq), .isa_zero_wait_o(zws), .bus_max_isa_o(max_isa),
        .mem_sram_sel_o(sram), .par_bidir_o(bidir), .osc_baud_sel_o(baud),
        .clk14_en_o(clk14), .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_wr_i(rwr),
        .reg_rd_i(rrd), .reg_rdata_o(rdata));

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // ==========================================================
    // Shared tasks
    task automatic results();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        raddr <= a;
        wdata <= d;
        rwr <= 1'b1;
        @(posedge clock_i);
        rwr <= 1'b0;
    endtask

    task automatic reg_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        raddr <= a;
        rrd <= 1'b1;
        @(posedge clock_i);
        rrd <= 1'b0;
        #1;
        chk(what, {15'h0000, exp}, {15'h0000, rdata});
    endtask

    // ==========================================================
    // Scenarios
    task automatic bus_reset(input logic [1:0] code);
        int n;
        @(posedge clock_i);
        strap_code <= code;
        main_rst_n <= 1'b0;
        io_rst_n <= 1'b0;
        repeat (6) @(posedge clock_i);
        #1;
        chk("strap oe in reset", 23'h0, {21'h0, strap_hi_oe, strap_lo_oe});
        @(posedge clock_i);
        main_rst_n <= 1'b1;
        io_rst_n <= 1'b1;
        n = 0;
        // Look after the edge so the enable is read once it has settled
        while (strap_hi_oe !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (strap_hi_oe !== 1'b1) begin
            n_mismatch++;
            results();
        end
        #1;
        chk("mode", {22'h0, code == 2'h3}, {22'h0, max_isa});
        reg_check("66h", 8'h66, (sw66 & 8'h9f) | {1'b0, code, 5'h00});
    endtask

    task automatic io_reset_only();
        @(posedge clock_i);
        io_rst_n <= 1'b0;
        strap_code <= 2'h2;
        repeat (6) @(posedge clock_i);
        io_rst_n <= 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
        chk("mode after io reset", 23'h1, {22'h0, max_isa});
        chk("strap oe after io reset", 23'h3, {21'h0, strap_hi_oe, strap_lo_oe});
    endtask

    task automatic modem_outputs();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            dtr <= i[1];
            rts <= i[0];
            repeat (2) @(posedge clock_i);
            #1;
            chk("strap pins", {21'h0, i[1:0]}, {21'h0, strap_hi, strap_lo});
        end
    endtask

    task automatic isa_pins();
        logic [22:0] e;
        for (int p = 0; p < 2; p++) begin
            @(posedge clock_i);
            ale <= ~p[0];
            dack <= p[0] ? 4'ha : 4'h5;
            la <= p[0] ? 7'h2a : 7'h55;
            below_1m <= p[0];
            periph <= p[0] ? 23'h2aaaaa : 23'h555555;
            repeat (5) @(posedge clock_i);
            #1;
            e = '0;
            e[0] = ale;
            e[4] = dack[0];
            e[3] = dack[1];
            e[1] = dack[2];
            e[2] = dack[3];
            e[11:5] = la;
            e[12] = below_1m;
            chk("isa pins", e, pad_o & `BOSM_OE_MAX_ISA);
            chk("isa oe", `BOSM_OE_MAX_ISA, pad_oe);
            chk("dma requests", {19'h0, periph[16:13]}, {19'h0, drq});
            chk("irqs", {18'h0, periph[21:17]}, {18'h0, irq});
            chk("zero wait", {22'h0, periph[22]}, {22'h0, zws});
        end
    endtask

    task automatic local_pins();
        logic [22:0] e;
        for (int p = 0; p < 2; p++) begin
            @(posedge clock_i);
            core_addr <= p[0] ? 12'h5a3 : 12'ha5c;
            {cpu_rdy, dc, mio, wr} <= p[0] ? 4'h5 : 4'ha;
            {byte_hi_en, byte_lo_en, addr_strobe} <= p[0] ? 3'h2 : 3'h5;
            periph <= p[0] ? 23'h7fffff : 23'h000000;
            repeat (5) @(posedge clock_i);
            #1;
            e = '0;
            e[11:0] = core_addr;
            e[16:12] = {wr, 1'b0, mio, dc, cpu_rdy};
            e[22:19] = {addr_strobe, byte_lo_en, 1'b0, byte_hi_en};
            chk("local pins", e, pad_o & `BOSM_OE_LOCAL);
            chk("local oe", `BOSM_OE_LOCAL, pad_oe);
            chk("local ready", {22'h0, periph[15]}, {22'h0, local_rdy});
            chk("isa inputs off", 23'h0, {13'h0, drq, irq, zws});
        end
    endtask

    task automatic registers();
        reg_write(8'h66, 8'hff);
        sw66 = 8'hff;
        reg_check("66h bits", 8'h66, 8'hdf);
        for (int b = 0; b < 4; b++) begin
            reg_write(8'h71, 8'h01 << b);
            reg_check("func select", 8'h71, 8'h01 << b);
            chk("func outputs", 23'h1 << b, {19'h0, clk14, baud, bidir, sram});
        end
        reg_write(8'h71, 8'hff);
        reg_check("func select full", 8'h71, 8'h0f);
        reg_write(8'h50, 8'hff);
        reg_check("unmapped", 8'h50, 8'h00);
        reg_check("66h kept", 8'h66, 8'hdf);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n_i, main_rst_n, io_rst_n, dtr, rts, rwr, rrd, ale, below_1m} = '0;
        {cpu_rdy, dc, mio, wr, byte_hi_en, byte_lo_en, addr_strobe} = '0;
        strap_code = 2'h3;
        dack = '0;
        la = '0;
        raddr = '0;
        wdata = '0;
        sw66 = '0;
        core_addr = '0;
        periph = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        bus_reset(2'h3);
        io_reset_only();
        isa_pins();
        modem_outputs();
        bus_reset(2'h2);
        local_pins();
        registers();
        results();
    end
endmodule
